/* dv/sdl_chk.sv */
`timescale 1ns/1ps
module sdl_chk
    import sdl_pkg::*;
(
    input wire logic                 clock,
    input wire logic                 reset,
    input wire logic                 latchReady,
    input wire logic                 latchValid,
    input wire logic [WORD_BITS-1:0] latchCode,
    input wire logic                 latchCorrupt,
    input wire logic                 dacCodeOk
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    property p_rst; $fell(reset) |-> (latchCode == LATCH_RESET && !latchValid) [*8]; endproperty
    a_rst: assert property (p_rst) else $error("rst");
    property p_hold; latchValid && !latchReady |=> latchValid && $stable(latchCode); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_chg; !$stable(latchCode) |-> latchValid; endproperty
    a_chg: assert property (p_chg) else $error("chg");
    property p_dv; dacCodeOk == !latchCorrupt; endproperty
    a_dv: assert property (p_dv) else $error("dv");
    property p_rdv; $fell(reset) |-> dacCodeOk && !latchCorrupt; endproperty
    a_rdv: assert property (p_rdv) else $error("rdv");
    property p_cor; !$stable(latchCorrupt) |-> latchValid; endproperty
    a_cor: assert property (p_cor) else $error("cor");
endmodule
bind sdl_serial_dac_word_loader sdl_chk chk_u (.*);

/* dv/sdl_host_model.sv */
`timescale 1ns/1ps
module sdl_host_model (
    input  wire logic linkClock,
    output logic      selectN = 1'b1,
    output logic      serialData = 1'b0
);
    task automatic send(input logic [15:0] w, input int n);
        @(negedge linkClock) selectN <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serialData <= w[i % 16];
            @(negedge linkClock);
        end
        selectN <= 1'b1;
        // released line: no stale bit
        serialData <= ~serialData;
        repeat (2) @(negedge linkClock);
    endtask
endmodule

/* dv/sdl_serial_dac_word_loader_tb.sv */
`timescale 1ns/1ps
module sdl_serial_dac_word_loader_tb;
    import sdl_pkg::*;
    logic clock = 0, reset = 1, linkClock = 0, latchReady = 0;
    logic selectN, serialData, latchValid, latchCorrupt, dacCodeOk;
    logic [WORD_BITS-1:0] latchCode;
    int num_errors = 0, cmp_count = 0;
    initial forever #2 clock = ~clock;
    initial #1.3 forever #16 linkClock = ~linkClock;
    sdl_host_model host_u (.*);
    sdl_serial_dac_word_loader dut_u (.*);
    task automatic take(input logic [15:0] w, input int n);
        logic ok;
        ok = n == 0 || n >= 16;
        @(posedge clock) #1;
        repeat (200) if (latchValid !== 1'b1) @(posedge clock) #1;
        cmp_count++;
        if ({latchValid, dacCodeOk, latchCorrupt} !== {n > 0, ok, !ok}
            || ok && latchCode !== w) begin
            num_errors++;
            $display("BAD %0t word %h", $time, w);
        end
        latchReady = 1;
        @(posedge clock) #1 latchReady = 0;
    endtask
    task automatic frame(input logic [15:0] w, input int n);
        host_u.send(w, n);
        take(w, n);
    endtask
    task automatic t_load;
        take(16'h0000, 0);
        frame(16'h8000, 16);
        frame(16'hA5C3, 16);
    endtask
    task automatic t_short;
        frame(16'h1234, 9);
        frame(16'hFFFF, 16);
        frame(16'h00FF, 20);
    endtask
    task automatic t_stall;
        host_u.send(16'h0F0F, 16);
        host_u.send(16'hF0F0, 16);
        take(16'h0F0F, 16);
        take(16'hF0F0, 16);
    endtask
    task test_done;
        $display("errors %0d of %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge linkClock);
        @(posedge clock) #1 reset = 0;
        t_load();
        t_short();
        t_stall();
        test_done();
    end
    initial begin
        #20000 num_errors++;
        test_done();
    end
endmodule

/* hw/sdl_pkg.sv */
// Functional notes
// R1: frame runs only while select low
// R2: shift data on serial clock rise
// R3: select rise copies word to latch
// R4: short frame gives corrupt latch value
// R5: host resends full word after short
// R6: latch clears to zero at power-up
// R7: host waits power-up delay before select
// R8: host serial clock max 10 MHz (the testbench runs linkClock at 31.25 MHz)
// R9: latch code is straight binary
// R10: most significant bit sent first
package sdl_pkg;
    localparam int WORD_BITS     = 16;
    localparam logic [15:0] LATCH_RESET = 16'h0000;
    localparam logic [4:0]  BIT_COUNT_RESET = 5'h00;

    typedef struct packed {
        logic [WORD_BITS-1:0] code;
        logic                 shortFrame;
    } sdl_word_t;
endpackage

/* hw/sdl_serial_dac_word_loader.sv */
`timescale 1ns/1ps
module sdl_serial_dac_word_loader
    import sdl_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 reset,
    input  wire logic                 linkClock,
    input  wire logic                 selectN,
    input  wire logic                 serialData,
    input  wire logic                 latchReady,
    output logic                      latchValid,
    output logic [WORD_BITS-1:0]      latchCode,
    output logic                      latchCorrupt,
    output logic                      dacCodeOk
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // a frame counts as good once a full word of clocks was seen
    function automatic logic frameComplete(input logic [4:0] count);
        return count == 5'(WORD_BITS);
    endfunction

    // two slots only, so a pointer is a single bit
    function automatic logic nextPtr(input logic ptr);
        return ~ptr;
    endfunction

    // ----------------------------------------
    // link domain: declarations
    // ----------------------------------------
    typedef enum logic {
        FRAME_IDLE,
        FRAME_SHIFT
    } sdl_phase_t;

    logic                 linkRstMeta_r;
    logic                 linkRst_r;
    logic [WORD_BITS-1:0] shift_r;
    logic [4:0]           bitCount_r;
    sdl_phase_t           phase_r;
    sdl_phase_t           phase_nxt;
    logic                 frameEnd;
    logic [WORD_BITS-1:0] heldCode_r;
    logic                 heldShort_r;
    logic                 linkToggle_r;

    // ----------------------------------------
    // link domain: reset synchroniser
    // ----------------------------------------
    // the link clock may stop between frames, so reset must stay
    // high long enough for a few link edges to pass
    always_ff @(posedge linkClock) begin
        linkRstMeta_r <= reset;
    end

    always_ff @(posedge linkClock) begin
        linkRst_r <= linkRstMeta_r;
    end

    // ----------------------------------------
    // link domain: shift register
    // ----------------------------------------
    // R2: shift on rise
    // R10: msb lands top
    always_ff @(posedge linkClock) begin
        if (linkRst_r) begin
            shift_r <= LATCH_RESET;
        // R1: select gates data
        end else if (!selectN) begin
            shift_r <= {shift_r[WORD_BITS-2:0], serialData};
        end
    end

    // ----------------------------------------
    // link domain: bit counter
    // ----------------------------------------
    // saturates at one word; a longer frame keeps its last sixteen bits
    always_ff @(posedge linkClock) begin
        if (linkRst_r) begin
            bitCount_r <= BIT_COUNT_RESET;
        end else if (!selectN) begin
            if (!frameComplete(bitCount_r)) begin
                bitCount_r <= bitCount_r + 5'h01;
            end
        end else begin
            bitCount_r <= BIT_COUNT_RESET;
        end
    end

    // ----------------------------------------
    // link domain: frame phase
    // ----------------------------------------
    // idle after reset, matching select's idle level: no false frame end
    always_comb begin
        phase_nxt = phase_r;
        case (phase_r)
            FRAME_IDLE: begin
                if (!selectN) begin
                    phase_nxt = FRAME_SHIFT;
                end
            end
            FRAME_SHIFT: begin
                if (selectN) begin
                    phase_nxt = FRAME_IDLE;
                end
            end
            default: begin
                phase_nxt = FRAME_IDLE;
            end
        endcase
    end

    always_ff @(posedge linkClock) begin
        if (linkRst_r) begin
            phase_r <= FRAME_IDLE;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // R3: select rise transfers
    assign frameEnd = (phase_r == FRAME_SHIFT) && selectN;

    // ----------------------------------------
    // link domain: held code
    // ----------------------------------------
    // stays put until the next frame ends, long after the crossing reads it
    always_ff @(posedge linkClock) begin
        if (linkRst_r) begin
            heldCode_r <= LATCH_RESET;
        end else if (frameEnd) begin
            heldCode_r <= shift_r;
        end
    end

    // ----------------------------------------
    // link domain: held flag
    // ----------------------------------------
    // R4: short flagged corrupt
    always_ff @(posedge linkClock) begin
        if (linkRst_r) begin
            heldShort_r <= 1'b0;
        end else if (frameEnd) begin
            heldShort_r <= !frameComplete(bitCount_r);
        end
    end

    // ----------------------------------------
    // link domain: handover toggle
    // ----------------------------------------
    // one toggle per word; only this bit is synchronised, the held code and flag are read directly by the system domain
    always_ff @(posedge linkClock) begin
        if (linkRst_r) begin
            linkToggle_r <= 1'b0;
        end else if (frameEnd) begin
            linkToggle_r <= ~linkToggle_r;
        end
    end

    // ----------------------------------------
    // crossing: toggle synchroniser
    // ----------------------------------------
    // two stages; nothing else reads the first
    logic togMeta_r;
    logic togSync_r;
    logic togSeen_r;
    logic newWord;

    always_ff @(posedge clock) begin
        if (reset) begin
            togMeta_r <= 1'b0;
            togSync_r <= 1'b0;
        end else begin
            togMeta_r <= linkToggle_r;
            togSync_r <= togMeta_r;
        end
    end

    // ----------------------------------------
    // crossing: toggle edge
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            togSeen_r <= 1'b0;
        end else begin
            togSeen_r <= togSync_r;
        end
    end

    assign newWord = togSync_r != togSeen_r;

    // ----------------------------------------
    // buffer: declarations
    // ----------------------------------------
    // a slow consumer stalls here; with one word in the latch and two buffered, a fourth word before any drain is dropped,
    // since the link has no way to push back on the host
    sdl_word_t          buf_r [2];
    logic               rdPtr_r;
    logic               wrPtr_r;
    logic [1:0]         count_r;
    logic               push;
    logic               pop;
    logic               bufFull;
    logic               bufEmpty;
    sdl_word_t          inWord;
    sdl_word_t          outWord;

    // ----------------------------------------
    // buffer: control
    // ----------------------------------------
    assign inWord  = '{code: heldCode_r, shortFrame: heldShort_r};
    assign outWord = buf_r[rdPtr_r];

    always_comb begin
        bufFull  = count_r == 2'h2;
        bufEmpty = count_r == 2'h0;
        pop      = !bufEmpty && (!latchValid || latchReady);
        push     = newWord && (!bufFull || pop);
    end

    // ----------------------------------------
    // buffer: storage
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!reset && push) begin
            buf_r[wrPtr_r] <= inWord;
        end
    end

    // ----------------------------------------
    // buffer: pointers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            wrPtr_r <= 1'b0;
        end else if (push) begin
            wrPtr_r <= nextPtr(wrPtr_r);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rdPtr_r <= 1'b0;
        end else if (pop) begin
            rdPtr_r <= nextPtr(rdPtr_r);
        end
    end

    // ----------------------------------------
    // buffer: occupancy
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            count_r <= 2'h0;
        end else begin
            count_r <= count_r + 2'(push) - 2'(pop);
        end
    end

    // ----------------------------------------
    // latch: valid
    // ----------------------------------------
    // a new word wins over the consumer's take in the same cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            latchValid <= 1'b0;
        end else if (pop) begin
            latchValid <= 1'b1;
        end else if (latchReady) begin
            latchValid <= 1'b0;
        end
    end

    // ----------------------------------------
    // latch: code
    // ----------------------------------------
    // R6: cleared at reset
    // R9: straight binary code
    always_ff @(posedge clock) begin
        if (reset) begin
            latchCode <= LATCH_RESET;
        end else if (pop) begin
            latchCode <= outWord.code;
        end
    end

    // ----------------------------------------
    // latch: flags
    // ----------------------------------------
    // R4: corrupt word flagged
    always_ff @(posedge clock) begin
        if (reset) begin
            latchCorrupt <= 1'b0;
        end else if (pop) begin
            latchCorrupt <= outWord.shortFrame;
        end
    end

    // the zero code left by reset is a valid output level
    always_ff @(posedge clock) begin
        if (reset) begin
            dacCodeOk <= 1'b1;
        end else if (pop) begin
            dacCodeOk <= !outWord.shortFrame;
        end
    end
endmodule
